// ### sim/cod_rx_model.sv
`timescale 1ns/1ps
module cod_rx_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // observed output line and its measured period
   input wire logic line,
   output logic [9:0] period,
   // clock sources
   output logic vco_tick,
   output logic ref_in
);
   logic [9:0] cnt;
   logic last;
   logic [1:0] ref_div;
   // one tick every cycle: fastest vco the block can see
   assign vco_tick = 1'b1;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt <= 10'h000;
         last <= 1'b0;
         period <= 10'h000;
         ref_in <= 1'b0;
         ref_div <= 2'h0;
      end else begin
         last <= line;
         // slow enough for the three-flop filter to follow
         ref_div <= ref_div + 2'h1;
         if (ref_div == 2'h3) ref_in <= ~ref_in;
         cnt <= (line && !last) ? 10'h001 : cnt + 10'h001;
         if (line && !last) period <= cnt;
      end
   end
endmodule

// ### sim/test_clock_output_divider_control.sv
`timescale 1ns/1ps
module test_clock_output_divider_control;
   import cod_pkg::*;
   logic core_clk, rst, avs_read, avs_write, avs_waitrequest, vco_tick, ref_in, se_out, se_oe;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q, seed;
   logic [3:0] pins [4];
   logic [9:0] period;
   cod_diff_t diff_out [OUT_COUNT];
   int sel, n_fail, checked, off, b, k, c;
   int base [3] = '{0, 4, 8};
   int cnt [3] = '{4, 4, 2};
   cod_output_ctrl cod_output_ctrl_i (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .vco_tick(vco_tick), .ref_in(ref_in),
      .bank_a_preset_pins(pins[0]), .bank_b_preset_pins(pins[1]), .bank_c_preset_pins(pins[2]),
      .bank_d_preset_pins(pins[3]), .diff_out(diff_out), .bank_d_single_ended_out(se_out),
      .bank_d_single_ended_oe(se_oe));
   cod_rx_model cod_rx_model_i (.core_clk(core_clk), .rst(rst), .line(diff_out[sel].p), .period(period),
      .vco_tick(vco_tick), .ref_in(ref_in));
   function automatic int ratio_of(int bk, int code);
      int ab [9] = '{16, 20, 25, 100, 0, 16, 20, 25, 50};
      int cc [9] = '{8, 16, 20, 100, 0, 20, 25, 50, 100};
      return (bk == 2) ? cc[code] : ab[code];
   endfunction
   task final_report;
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         $display("wrong value waitrequest expected 0 seen %b", avs_waitrequest);
         n_fail++;
         final_report;
      end
      @(posedge core_clk);
   endtask
   task set_code(input int bk, input int code);
      logic [1:0] p1, p0;
      p1 = 2'(code / 3);
      p0 = 2'(code % 3);
      if (p1 == LVL_MID && $random(seed) % 2 == 0) p1 = LVL_OPEN;
      pins[bk] <= {p1, p0};
      tick(8);
   endtask
   task chk_bank(input int bk, input int code);
      int i;
      for (i = base[bk]; i < base[bk] + cnt[bk]; i++) begin
         if (code == 4) chk("pin pd", 32'h3, {30'h0, diff_out[i].p, diff_out[i].n});
         else chk("pin type", {29'h0, code < 4, code < 4 ? SWING_750 : SWING_350}, 32'({diff_out[i].lvpecl, diff_out[i].swing}));
      end
      if (code != 4) begin
         sel <= base[bk];
         tick(2 * ratio_of(bk, code) + 8);
         chk("pin ratio", 32'(ratio_of(bk, code)), 32'(period));
      end
   endtask
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      seed = 32'h4197;
      {n_fail, checked, sel} = '0;
      {rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 42'h0};
      for (c = 0; c < 4; c++) pins[c] = 4'hF;
      tick(3);
      rst <= 1'b0;
      tick(8);
      chk("open pd", 32'h1E, 32'({diff_out[0].p, diff_out[0].n, diff_out[10].p, diff_out[10].n, se_oe}));
      off = $unsigned($random(seed)) % 9;
      for (b = 0; b < 3; b++) for (k = 0; k < 9; k++) begin
         set_code(b, (k + off) % 9);
         chk_bank(b, (k + off) % 9);
      end
      set_code(3, 8);
      chk("bypass", 32'h1, 32'({diff_out[10].lvpecl, se_oe}));
      sel <= 10;
      tick(30);
      chk("bypass period", 32'h8, 32'(period));
      set_code(3, 2);
      tick(50);
      chk("frac period", 32'h1, 32'(period == 10'h012 || period == 10'h013));
      bus(0, CTRL_OFS, 32'h0);
      chk("ctrl", CTRL_RST, q);
      bus(0, BANK_A_OFS, 32'h0);
      chk("bank a", BANK_RST, q);
      bus(1, 8'h40, $random(seed));
      bus(0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, q);
      bus(1, CTRL_OFS, 32'h0000000E);
      sel <= 0;
      tick(40);
      chk("reg ratio", 32'd16, 32'(period));
      bus(1, BANK_A_OFS, 32'h00162208);
      tick(40);
      chk("no init", 32'd16, 32'(period));
      chk("out0 type", 32'h5, 32'({diff_out[0].lvpecl, diff_out[0].swing}));
      chk("out1 pd", 32'h3, 32'({diff_out[1].p, diff_out[1].n}));
      bus(1, CTRL_OFS, 32'h0000010E);
      tick(24);
      chk("init ratio", 32'd8, 32'(period));
      bus(1, BANK_A_OFS, 32'h00160008);
      tick(4);
      chk("disabled", 32'h1, 32'({diff_out[0].p, diff_out[0].n}));
      final_report;
   end
endmodule

// ### src/cod_output_ctrl.sv
`timescale 1ns/1ps
// What this block does
// (RL1) banks a, b, c divide only the pll clock
// (RL2) bank d can pass the selected reference straight to its output
// (RL3) four integer dividers, one per bank, each set independently
// (RL4) bank d picks integer or fractional divider by a source select
// (RL5) integer ratios from the listed set; output is vco over ratio
// (RL6) fractional output is vco over two times (int plus frac) times post divider
// (RL7) fractional integer part is four bits, valid 5 to 15
// (RL8) fractional part is 24 bits, any value
// (RL9) post divider code selects divide by 1, 2 or 4
// (RL10) each differential output selects lvds, lvpecl or power-down
// (RL11) power-down drives both pins high; single-ended output goes high-z
// (RL12) each differential output selects 350, 500 or 750 mv swing
// (RL13) pin control gives all outputs of a bank one configuration
// (RL14) pin selections act directly and leave stored registers unchanged
// (RL15) registers power and enable banks; outputs have own power-down
// (RL16) outputs come up enabled without any register write
// (RL17) disabled: true low, complement high; single-ended output low
// (RL18) bank a pin pair table of lvpecl, power-down and lvds presets
// (RL19) bank b pin pair decodes as bank a
// (RL20) bank c pin pair table of lvpecl, power-down and lvds presets
// (RL21) pin-controlled lvpecl uses 750 mv swing
// (RL22) pin-controlled lvds uses 350 mv swing
// (RL23) new register divider values load and resync only on init
// (RL24) an open three-level pin reads as middle
// (RL25) bank d high-high: lvds, single-ended on, bypass divide 1
// (RL26) each pin pair decodes nine ways into ratio, driver and swing
module cod_output_ctrl (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // clock sources
   input wire logic vco_tick,
   input wire logic ref_in,
   // three-level preset pins, two level codes per bank
   input wire logic [3:0] bank_a_preset_pins,
   input wire logic [3:0] bank_b_preset_pins,
   input wire logic [3:0] bank_c_preset_pins,
   input wire logic [3:0] bank_d_preset_pins,
   // outputs; index 10 is the bank d differential output
   output cod_pkg::cod_diff_t diff_out [cod_pkg::OUT_COUNT],
   output logic bank_d_single_ended_out,
   output logic bank_d_single_ended_oe
);
   import cod_pkg::*;

   logic [31:0] bank_reg [BANK_COUNT];
   logic [31:0] next_bank_reg [BANK_COUNT];
   logic [3:0] pin_ctl, next_pin_ctl;
   logic [31:0] frac_reg, next_frac_reg;
   logic init_pulse, next_init_pulse;
   logic next_waitrequest;
   logic [31:0] next_readdata;
   logic [15:0] pin_s1, pin_s2, pin_s3, pin_now, next_pin_now;
   logic ref_s1, ref_s2, ref_s3, ref_lvl, next_ref_lvl;
   logic [7:0] int_cnt [BANK_COUNT];
   logic [7:0] next_int_cnt [BANK_COUNT];
   logic [7:0] loaded_ratio [BANK_COUNT];
   logic [7:0] next_loaded_ratio [BANK_COUNT];
   logic [3:0] ld_frac_integer_value, next_ld_frac_integer_value;
   logic [23:0] ld_frac, next_ld_frac;
   logic [1:0] ld_divf, next_ld_divf;
   logic [23:0] frac_acc, next_frac_acc;
   logic [3:0] pre_cnt, next_pre_cnt;
   logic [2:0] post_cnt, next_post_cnt;
   logic frac_lvl, next_frac_lvl;
   cod_preset_t preset [BANK_COUNT];
   logic [3:0] eff_pd;
   logic [7:0] eff_ratio [BANK_COUNT];
   logic [1:0] eff_src;
   logic [3:0] eff_frac_integer_value;
   logic [23:0] eff_frac;
   logic [1:0] eff_divf;
   logic [3:0] int_lvl;
   logic [24:0] acc_sum;
   cod_diff_t next_diff [OUT_COUNT];
   logic next_aux_out, next_aux_oe;
   logic aux_pd, aux_off, lvl_d;

   function automatic logic [1:0] pin_level(input logic [1:0] code);
      pin_level = (code == LVL_OPEN) ? LVL_MID : code; // RL24
   endfunction

   function automatic logic ratio_ok(input logic [7:0] r);
      case (r)
         8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h0C, 8'h10, 8'h12, 8'h14, 8'h19,
         8'h20, 8'h24, 8'h28, 8'h32, 8'h40, 8'h48, 8'h50, 8'h64, 8'h80, 8'hA0, 8'hC8, 8'hDC: ratio_ok = 1'b1;
         default: ratio_ok = 1'b0;
      endcase
   endfunction

   function automatic logic [2:0] post_ratio(input logic [1:0] code);
      case (code)
         2'h1: post_ratio = 3'h2;
         2'h2: post_ratio = 3'h4;
         default: post_ratio = 3'h1;
      endcase
   endfunction

   function automatic int bank_of(input int i);
      bank_of = (i < 4) ? 0 : (i < 8) ? 1 : (i < 10) ? 2 : 3;
   endfunction

   function automatic int first_of(input int b);
      first_of = (b == 0) ? 0 : (b == 1) ? 4 : (b == 2) ? 8 : 10;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      for (int k = 0; k < 4; k++) begin
         merge[8*k +: 8] = be[k] ? wd[8*k +: 8] : old[8*k +: 8];
      end
   endfunction

   // nine-way pin decode per bank
   function automatic cod_preset_t decode_preset(input int b, input logic [3:0] code);
      logic [3:0] sel;
      cod_preset_t p;
      sel = 4'(pin_level(code[3:2]) * 2'h3) + 4'(pin_level(code[1:0])); // RL26
      p = '0;
      p.ratio = 8'h01;
      p.frac_integer_value = FRAC_RST[FRAC_FRAC_INTEGER_VALUE_LSB +: 4];
      p.frac_fraction_part = FRAC_RST[FRAC_FRAC_LSB +: 24];
      if (b < 3) begin
         p.pd = (sel == 4'h4);
         p.lvpecl = (sel < 4'h4);
         if (b == 2) begin
            case (sel) // RL20
               4'h0: p.ratio = 8'h08;
               4'h1: p.ratio = 8'h10;
               4'h2, 4'h5: p.ratio = 8'h14;
               4'h6: p.ratio = 8'h19;
               4'h7: p.ratio = 8'h32;
               4'h3, 4'h8: p.ratio = 8'h64;
               default: p.ratio = 8'h01;
            endcase
         end else begin
            case (sel) // RL18 RL19
               4'h0, 4'h5: p.ratio = 8'h10;
               4'h1, 4'h6: p.ratio = 8'h14;
               4'h2, 4'h7: p.ratio = 8'h19;
               4'h3: p.ratio = 8'h64;
               4'h8: p.ratio = 8'h32;
               default: p.ratio = 8'h01;
            endcase
         end
      end else begin
         case (sel)
            4'h0: p.ratio = 8'h19;
            4'h1: p.ratio = 8'h32;
            4'h2: p.src = SRC_FRAC;
            4'h3: begin
               p.src = SRC_FRAC;
               p.frac_post_divider = 2'h1;
            end
            4'h4: p.pd = 1'b1;
            4'h5: begin
               p.pd = 1'b1;
               p.aux_on = 1'b1;
               p.src = SRC_FRAC;
               p.frac_post_divider = 2'h2;
            end
            4'h6: p.ratio = 8'h64;
            4'h7: p.ratio = 8'h14;
            4'h8: begin // RL25
               p.src = SRC_BYPASS;
               p.aux_on = 1'b1;
            end
            default: p.ratio = 8'h01;
         endcase
      end
      decode_preset = p;
   endfunction

   // effective settings: pins override registers without touching them
   always_comb begin
      for (int b = 0; b < BANK_COUNT; b++) begin
         preset[b] = decode_preset(b, pin_now[4*b +: 4]);
         if (pin_ctl[b]) begin // RL14
            eff_pd[b] = preset[b].pd;
            eff_ratio[b] = preset[b].ratio;
         end else begin
            eff_pd[b] = bank_reg[b][BANK_PD_BIT]; // RL15
            eff_ratio[b] = loaded_ratio[b];
         end
      end
      if (pin_ctl[3]) begin
         eff_src = preset[3].src;
         eff_frac_integer_value = preset[3].frac_integer_value;
         eff_frac = preset[3].frac_fraction_part;
         eff_divf = preset[3].frac_post_divider;
      end else begin
         eff_src = bank_reg[3][BANK_SRC_LSB +: 2]; // RL4
         eff_frac_integer_value = ld_frac_integer_value;
         eff_frac = ld_frac;
         eff_divf = ld_divf;
      end
   end

   // avalon slave and register file
   always_comb begin
      next_waitrequest = 1'b1;
      next_readdata = avs_readdata;
      next_pin_ctl = pin_ctl;
      next_frac_reg = frac_reg;
      next_init_pulse = 1'b0;
      for (int b = 0; b < BANK_COUNT; b++) begin
         next_bank_reg[b] = bank_reg[b];
      end
      if ((avs_read || avs_write) && avs_waitrequest) begin
         next_waitrequest = 1'b0;
      end
      if (avs_read && avs_waitrequest) begin
         case (avs_address)
            CTRL_OFS: next_readdata = {28'h0000000, pin_ctl};
            BANK_A_OFS: next_readdata = bank_reg[0];
            BANK_B_OFS: next_readdata = bank_reg[1];
            BANK_C_OFS: next_readdata = bank_reg[2];
            BANK_D_OFS: next_readdata = bank_reg[3];
            FRAC_OFS: next_readdata = frac_reg;
            STATUS_OFS: next_readdata = {16'h0000, loaded_ratio[3], 2'h0, eff_src, eff_pd};
            default: next_readdata = 32'h00000000;
         endcase
      end
      if (avs_write && !avs_waitrequest) begin
         case (avs_address)
            CTRL_OFS: begin
               if (avs_byteenable[0]) begin
                  next_pin_ctl = avs_writedata[CTRL_PIN_CTL_LSB +: 4];
               end
               next_init_pulse = avs_byteenable[1] && avs_writedata[CTRL_INIT_BIT]; // RL23
            end
            BANK_A_OFS: next_bank_reg[0] = merge(bank_reg[0], avs_writedata, avs_byteenable);
            BANK_B_OFS: next_bank_reg[1] = merge(bank_reg[1], avs_writedata, avs_byteenable);
            BANK_C_OFS: next_bank_reg[2] = merge(bank_reg[2], avs_writedata, avs_byteenable);
            BANK_D_OFS: next_bank_reg[3] = merge(bank_reg[3], avs_writedata, avs_byteenable);
            FRAC_OFS: next_frac_reg = merge(frac_reg, avs_writedata, avs_byteenable);
            default: next_frac_reg = frac_reg;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
         pin_ctl <= CTRL_RST[CTRL_PIN_CTL_LSB +: 4];
         frac_reg <= FRAC_RST;
         init_pulse <= 1'b0;
         for (int b = 0; b < BANK_COUNT; b++) begin
            bank_reg[b] <= BANK_RST; // RL16
         end
      end else begin
         avs_waitrequest <= next_waitrequest;
         avs_readdata <= next_readdata;
         pin_ctl <= next_pin_ctl;
         frac_reg <= next_frac_reg;
         init_pulse <= next_init_pulse;
         for (int b = 0; b < BANK_COUNT; b++) begin
            bank_reg[b] <= next_bank_reg[b];
         end
      end
   end

   // pin and reference synchronisers
   always_comb begin
      for (int k = 0; k < 16; k++) begin
         next_pin_now[k] = (pin_s2[k] == pin_s3[k]) ? pin_s2[k] : pin_now[k];
      end
      next_ref_lvl = (ref_s2 == ref_s3) ? ref_s2 : ref_lvl;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_s1 <= 16'h5555;
         pin_s2 <= 16'h5555;
         pin_s3 <= 16'h5555;
         pin_now <= 16'h5555;
         ref_s1 <= 1'b0;
         ref_s2 <= 1'b0;
         ref_s3 <= 1'b0;
         ref_lvl <= 1'b0;
      end else begin
         pin_s1 <= {bank_d_preset_pins, bank_c_preset_pins, bank_b_preset_pins, bank_a_preset_pins};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_now <= next_pin_now;
         ref_s1 <= ref_in;
         ref_s2 <= ref_s1;
         ref_s3 <= ref_s2;
         ref_lvl <= next_ref_lvl;
      end
   end

   // integer and fractional dividers, all counting pll ticks
   always_comb begin
      acc_sum = {1'b0, frac_acc} + {1'b0, eff_frac}; // RL8
      next_frac_acc = frac_acc;
      next_pre_cnt = pre_cnt;
      next_post_cnt = post_cnt;
      next_frac_lvl = frac_lvl;
      next_ld_frac_integer_value = ld_frac_integer_value;
      next_ld_frac = ld_frac;
      next_ld_divf = ld_divf;
      for (int b = 0; b < BANK_COUNT; b++) begin
         next_loaded_ratio[b] = loaded_ratio[b];
         next_int_cnt[b] = int_cnt[b];
         int_lvl[b] = (eff_ratio[b] == 8'h01) ? vco_tick : (int_cnt[b] < (eff_ratio[b] >> 1)); // RL5
         if (init_pulse) begin
            next_int_cnt[b] = 8'h00; // RL23
            if (ratio_ok(bank_reg[b][BANK_DIV_LSB +: 8])) begin
               next_loaded_ratio[b] = bank_reg[b][BANK_DIV_LSB +: 8]; // RL3
            end
         end else if (vco_tick) begin
            next_int_cnt[b] = (int_cnt[b] >= eff_ratio[b] - 8'h01) ? 8'h00 : int_cnt[b] + 8'h01; // RL1
         end
      end
      if (init_pulse) begin
         next_frac_acc = 24'h000000;
         next_pre_cnt = 4'h0;
         next_post_cnt = 3'h0;
         next_frac_lvl = 1'b0;
         if (frac_reg[FRAC_FRAC_INTEGER_VALUE_LSB +: 4] >= FRAC_INTEGER_VALUE_MIN && frac_reg[FRAC_DIVF_LSB +: 2] != 2'h3) begin // RL7
            next_ld_frac_integer_value = frac_reg[FRAC_FRAC_INTEGER_VALUE_LSB +: 4];
            next_ld_frac = frac_reg[FRAC_FRAC_LSB +: 24];
            next_ld_divf = frac_reg[FRAC_DIVF_LSB +: 2];
         end
      end else if (vco_tick) begin
         if (pre_cnt == 4'h0) begin
            // carry stretches one interval by a tick: average is frac_integer_value plus frac
            next_frac_acc = acc_sum[23:0];
            next_pre_cnt = eff_frac_integer_value - 4'h1 + {3'h0, acc_sum[24]}; // RL6
            if (post_cnt >= post_ratio(eff_divf) - 3'h1) begin // RL9
               next_post_cnt = 3'h0;
               next_frac_lvl = ~frac_lvl;
            end else begin
               next_post_cnt = post_cnt + 3'h1;
            end
         end else begin
            next_pre_cnt = pre_cnt - 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         frac_acc <= 24'h000000;
         pre_cnt <= 4'h0;
         post_cnt <= 3'h0;
         frac_lvl <= 1'b0;
         ld_frac_integer_value <= FRAC_RST[FRAC_FRAC_INTEGER_VALUE_LSB +: 4];
         ld_frac <= FRAC_RST[FRAC_FRAC_LSB +: 24];
         ld_divf <= FRAC_RST[FRAC_DIVF_LSB +: 2];
         for (int b = 0; b < BANK_COUNT; b++) begin
            int_cnt[b] <= 8'h00;
            loaded_ratio[b] <= RATIO_RST;
         end
      end else begin
         frac_acc <= next_frac_acc;
         pre_cnt <= next_pre_cnt;
         post_cnt <= next_post_cnt;
         frac_lvl <= next_frac_lvl;
         ld_frac_integer_value <= next_ld_frac_integer_value;
         ld_frac <= next_ld_frac;
         ld_divf <= next_ld_divf;
         for (int b = 0; b < BANK_COUNT; b++) begin
            int_cnt[b] <= next_int_cnt[b];
            loaded_ratio[b] <= next_loaded_ratio[b];
         end
      end
   end

   // output drivers
   always_comb begin
      case (eff_src)
         SRC_FRAC: lvl_d = frac_lvl;
         SRC_BYPASS: lvl_d = ref_lvl; // RL2
         default: lvl_d = int_lvl[3];
      endcase
      for (int i = 0; i < OUT_COUNT; i++) begin
         int b;
         int f;
         logic lvl;
         logic out_pd;
         b = bank_of(i);
         f = BANK_OUT_LSB + OUT_FIELD_W * (i - first_of(b));
         lvl = (b == 3) ? lvl_d : int_lvl[b];
         out_pd = eff_pd[b] || (!pin_ctl[b] && bank_reg[b][f + OUT_PD_OFS]); // RL15
         if (pin_ctl[b]) begin // RL13
            next_diff[i].lvpecl = preset[b].lvpecl;
            next_diff[i].swing = preset[b].lvpecl ? SWING_750 : SWING_350; // RL21 RL22
         end else begin
            next_diff[i].lvpecl = bank_reg[b][f + OUT_TYPE_OFS]; // RL10
            next_diff[i].swing = bank_reg[b][f + OUT_SWING_OFS +: 2]; // RL12
         end
         if (out_pd) begin
            next_diff[i].p = 1'b1; // RL11
            next_diff[i].n = 1'b1;
         end else if (!bank_reg[b][BANK_EN_BIT]) begin
            next_diff[i].p = 1'b0; // RL17
            next_diff[i].n = 1'b1;
         end else begin
            next_diff[i].p = lvl;
            next_diff[i].n = ~lvl;
         end
      end
      aux_pd = pin_ctl[3] ? !preset[3].aux_on : (bank_reg[3][BANK_PD_BIT] || bank_reg[3][BANK_AUX_PD_BIT]);
      aux_off = !bank_reg[3][BANK_EN_BIT] || (!pin_ctl[3] && !bank_reg[3][BANK_AUX_EN_BIT]);
      next_aux_oe = !aux_pd; // RL11
      next_aux_out = !aux_pd && !aux_off && lvl_d; // RL17
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < OUT_COUNT; i++) begin
            diff_out[i] <= '{p: 1'b1, n: 1'b1, lvpecl: 1'b0, swing: SWING_350};
         end
         bank_d_single_ended_out <= 1'b0;
         bank_d_single_ended_oe <= 1'b0;
      end else begin
         for (int i = 0; i < OUT_COUNT; i++) begin
            diff_out[i] <= next_diff[i];
         end
         bank_d_single_ended_out <= next_aux_out;
         bank_d_single_ended_oe <= next_aux_oe;
      end
   end

   // checks
   chk_wait_one_cycle: assert property (@(posedge core_clk) disable iff (rst) // avalon read: waitrequest low for one cycle
      (avs_read && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest not low for exactly one cycle");
   chk_init_resync: assert property (@(posedge core_clk) disable iff (rst) // RL23
      init_pulse |=> (int_cnt[0] == 8'h00 && int_cnt[1] == 8'h00 && int_cnt[2] == 8'h00 && int_cnt[3] == 8'h00))
      else $error("dividers not resynchronised by init");
   chk_ratio_hold: assert property (@(posedge core_clk) disable iff (rst) // RL23
      !init_pulse |=> $stable(loaded_ratio[0]))
      else $error("divider ratio changed without init");
   chk_pins_keep_regs: assert property (@(posedge core_clk) disable iff (rst) // RL14
      (!$past(avs_write) && $changed(pin_now)) |-> $stable(bank_reg[0]) && $stable(bank_reg[3]))
      else $error("pin change altered register contents");
   chk_pd_both_high: assert property (@(posedge core_clk) disable iff (rst) // RL11
      (pin_ctl[0] && pin_now[3:0] == {LVL_MID, LVL_MID}) |=> (diff_out[0].p && diff_out[3].n))
      else $error("powered-down bank a output not high");
   chk_disable_low: assert property (@(posedge core_clk) disable iff (rst) // RL17
      (!eff_pd[0] && !bank_reg[0][BANK_EN_BIT] && !bank_reg[0][BANK_OUT_LSB]) |=> (!diff_out[0].p && diff_out[0].n))
      else $error("disabled output not low-high");
   chk_pecl_swing: assert property (@(posedge core_clk) disable iff (rst) // RL21
      (pin_ctl[2] && pin_now[11:8] == {LVL_LOW, LVL_LOW}) [*2] |=> (diff_out[8].lvpecl && diff_out[9].swing == SWING_750))
      else $error("pin lvpecl bank not at 750 mv");
   chk_lvds_swing: assert property (@(posedge core_clk) disable iff (rst) // RL22
      (pin_ctl[0] && pin_now[3:2] == LVL_HIGH) |=> (!diff_out[1].lvpecl && diff_out[2].swing == SWING_350))
      else $error("pin lvds bank not at 350 mv");
   chk_aux_hiz: assert property (@(posedge core_clk) disable iff (rst) // RL11
      (pin_ctl[3] && pin_now[15:12] == {LVL_MID, LVL_MID}) |=> !bank_d_single_ended_oe)
      else $error("single-ended output driven in power-down");
   chk_open_is_mid: assert property (@(posedge core_clk) disable iff (rst) // RL24
      (pin_ctl[0] && pin_now[3:0] == {LVL_OPEN, LVL_OPEN}) |-> eff_pd[0])
      else $error("open pins not decoded as middle");
   chk_bypass_path: assert property (@(posedge core_clk) disable iff (rst) // RL25
      (pin_ctl[3] && pin_now[15:12] == {LVL_HIGH, LVL_HIGH} && bank_reg[3][BANK_EN_BIT]) |=>
      (diff_out[10].p == $past(ref_lvl) && bank_d_single_ended_oe))
      else $error("bank d bypass not following reference");

endmodule

// ### src/cod_pkg.sv
package cod_pkg;

   // register byte offsets on the avalon slave
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] BANK_A_OFS = 8'h04;
   localparam logic [7:0] BANK_B_OFS = 8'h08;
   localparam logic [7:0] BANK_C_OFS = 8'h0C;
   localparam logic [7:0] BANK_D_OFS = 8'h10;
   localparam logic [7:0] FRAC_OFS = 8'h14;
   localparam logic [7:0] STATUS_OFS = 8'h18;

   // control register fields
   localparam int CTRL_PIN_CTL_LSB = 0;
   localparam int CTRL_INIT_BIT = 8;
   localparam logic [31:0] CTRL_RST = 32'h0000000F;

   // bank register fields
   localparam int BANK_DIV_LSB = 0;
   localparam int BANK_PD_BIT = 8;
   localparam int BANK_EN_BIT = 9;
   localparam int BANK_SRC_LSB = 10;
   localparam int BANK_AUX_PD_BIT = 12;
   localparam int BANK_AUX_EN_BIT = 13;
   localparam int BANK_OUT_LSB = 16;
   localparam int OUT_FIELD_W = 4;
   localparam int OUT_PD_OFS = 0;
   localparam int OUT_TYPE_OFS = 1;
   localparam int OUT_SWING_OFS = 2;
   localparam logic [31:0] BANK_RST = 32'h00002210;
   localparam logic [7:0] RATIO_RST = 8'h10;

   // fractional divider register fields
   localparam int FRAC_FRAC_LSB = 0;
   localparam int FRAC_FRAC_INTEGER_VALUE_LSB = 24;
   localparam int FRAC_DIVF_LSB = 28;
   localparam logic [31:0] FRAC_RST = 32'h09600000;
   localparam logic [3:0] FRAC_INTEGER_VALUE_MIN = 4'h5;

   // output layout: banks a, b, c, d hold 4, 4, 2, 1 differential outputs
   localparam int BANK_COUNT = 4;
   localparam int OUT_COUNT = 11;

   // three-level pin codes from the pin receivers
   localparam logic [1:0] LVL_LOW = 2'h0;
   localparam logic [1:0] LVL_MID = 2'h1;
   localparam logic [1:0] LVL_HIGH = 2'h2;
   localparam logic [1:0] LVL_OPEN = 2'h3;

   // swing codes
   localparam logic [1:0] SWING_350 = 2'h0;
   localparam logic [1:0] SWING_500 = 2'h1;
   localparam logic [1:0] SWING_750 = 2'h2;

   // bank d source select
   localparam logic [1:0] SRC_INT = 2'h0;
   localparam logic [1:0] SRC_FRAC = 2'h1;
   localparam logic [1:0] SRC_BYPASS = 2'h2;

   // preset decoded from one bank's pin pair
   typedef struct packed {
      logic pd;
      logic lvpecl;
      logic [7:0] ratio;
      logic [1:0] src;
      logic aux_on;
      logic [3:0] frac_integer_value;
      logic [23:0] frac_fraction_part;
      logic [1:0] frac_post_divider;
   } cod_preset_t;

   // one differential output and its driver settings
   typedef struct packed {
      logic p;
      logic n;
      logic lvpecl;
      logic [1:0] swing;
   } cod_diff_t;

endpackage
